//--- test/hec_rf_model.sv
// Purpose: RF stage model that drains the code word stream.
// Assumes: It shares clk_sys with the core.
// Notes: Only the last two words taken are kept.
`default_nettype none

module hec_rf_model import hec_pkg::*; (
  // Clock, reset and stall request.
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic stall,
  // Code word stream.
  input wire logic [WORD_W-1:0] cw_data,
  input wire logic cw_valid,
  output logic cw_ready,
  // Words taken and their count.
  output logic [WORD_W-1:0] prev_word,
  output logic [WORD_W-1:0] last_word,
  output logic [7:0] n_words
);
  timeunit 1ns;
  timeprecision 1ns;
  // A stalled stage refuses words, so the core must hold them.
  assign cw_ready = ~stall;
  // Take a word at each handshake edge.
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      n_words <= 8'h00;
    end else if (cw_valid && cw_ready) begin
      prev_word <= last_word;
      last_word <= cw_data;
      n_words <= n_words + 8'h01;
    end
  end
endmodule : hec_rf_model

`default_nettype wire

//--- test/testbench.sv
// Purpose: Self-checking bench of the hopping encoder control core.
// Assumes: Shortened debounce, slot and timer counts.
// Notes: RF stage stalls are random from a fixed seed.
`default_nettype none

module testbench import hec_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, resetn = 0, prog_entry = 0, pwm_in = 0, stall = 0;
  logic low6 = 0, hold = 0; // Low supply comparator and a forced stall of the RF stage.
  logic pwm_out, pwm_oe, ind_n;
  logic [3:0] btn = 4'h0;
  logic [WORD_W-1:0] cw_data, prev_word, last_word;
  logic cw_valid, cw_ready;
  logic [7:0] n_words;
  logic [63:0] cipher_key;
  logic [15:0] mem [12];
  logic [31:0] rs = 32'hd575;
  int n_errors = 0, n_checks = 0, cyc = 0;

  hec_core #(.DEBOUNCE_CYCLES(20), .SHUTOFF_CYCLES(2000), .ELEM_SLOW_CYCLES(8),
    .BLINK_CYCLES(10)) dut (.clk_sys(clk_sys), .resetn(resetn), .button_input_0(btn[0]),
    .button_input_1(btn[1]), .button_input_2(btn[2]), .button_input_3(btn[3]),
    .prog_entry(prog_entry), .pwm_in(pwm_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
    .supply_low_6v(low6), .supply_low_12v(1'b0), .indicator_cathode_pin_n(ind_n),
    .cipher_key(cipher_key), .cw_data(cw_data), .cw_valid(cw_valid), .cw_ready(cw_ready));
  hec_rf_model rf (.clk_sys(clk_sys), .resetn(resetn), .stall(stall), .cw_data(cw_data),
    .cw_valid(cw_valid), .cw_ready(cw_ready), .prev_word(prev_word), .last_word(last_word),
    .n_words(n_words));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  // Hop plaintext: buttons, wrap flags after the first wrap, discrimination, counter.
  function automatic logic [WORD_W-1:0] hop_exp(input logic [3:0] b, input logic [15:0] c);
    if (b == 4'hF) return {2'h0, mem[9], mem[8]};
    return {2'h0, b, 2'h2, mem[11][9:0], c};
  endfunction : hop_exp
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected %s exp %h got %h", what, exp, got);
      n_errors++;
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // Shift the store in, least significant bit first, word 0 first.
  task automatic program_store;
    prog_entry = 1'b1;
    tick(4);
    chk("drive enable", pwm_oe, 1'b0);
    for (int w = 0; w < NV_WORDS; w++)
      for (int k = 0; k < 16; k++) begin
        pwm_in = mem[w][k];
        tick(3);
        btn[2] = 1'b1;
        tick(3);
        btn[2] = 1'b0;
        tick(3);
      end
    prog_entry = 1'b0;
    tick(4);
  endtask : program_store
  // Press a, switch to b once sending starts (a restart when b adds a button),
  // then let one slot run, or with s hold the button until the timer stops it.
  // The forced stall keeps the aborted words in the buffer so the flush is seen.
  task automatic press(input logic [3:0] a, b, input logic [15:0] c, input logic v, s);
    logic [7:0] n0, nw;
    n0 = n_words;
    nw = n0 + (s ? 8'h04 : 8'h02);
    low6 = v;
    hold = (a != b);
    btn = a;
    for (int i = 0; i < 100 && pwm_out !== 1'b1; i++) tick(1);
    chk("drive enable", pwm_oe, 1'b1);
    if (!v) chk("indicator", ind_n, 1'b0);
    btn = b;
    tick(5);
    hold = 1'b0;
    for (int i = 0; i < 3000 && n_words != nw; i++) tick(1);
    if (!s) btn = 4'h0;
    chk("hop word", prev_word, hop_exp(b, c));
    chk("fixed word", last_word, {v, s, b, mem[7][11:0], mem[6]});
    chk("carrier on", pwm_out, 1'b1);
    tick(1500);
    chk("word count", n_words, nw);
    chk("carrier off", pwm_out, 1'b0);
    btn = 4'h0;
    tick(4);
    $display("press %h done", b);
  endtask : press

  // Free-running clock of 50 ns.
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // Random stalls of the RF stage, and a ceiling on run length.
  always @(posedge clk_sys) begin
    #2;
    rs = xs(rs);
    stall = (rs[0] & rs[1]) | hold;
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  // Main sequence.
  initial begin
    for (int w = 0; w < NV_WORDS; w++) begin
      rs = xs(rs);
      mem[w] = rs[15:0];
    end
    mem[4] = 16'hFFFF; // The first press wraps the counter.
    mem[5] = 16'h0000;
    mem[7][15] = 1'b1; // Stuck-button timer on; a slot is shorter than its limit.
    mem[10] = 16'h0000;
    mem[11][15:10] = 6'h03; // Slowest rate, both wrap flags set.
    tick(16);
    resetn = 1'b1;
    program_store();
    chk("key", cipher_key, {mem[3], mem[2], mem[1], mem[0]});
    $display("store loaded");
    press(4'h1, 4'h1, 16'h0000, 1'b0, 1'b0);
    press(4'h1, 4'h3, 16'h0002, 1'b1, 1'b0); // Restart
    press(4'h2, 4'h2, 16'h0003, 1'b0, 1'b1); // Stuck button
    press(4'hF, 4'hF, 16'h0004, 1'b0, 1'b0);
    end_of_test();
  end
endmodule : testbench

`default_nettype wire

//--- verilog/hec_buf2.sv
// Purpose: Two-entry buffer between the code word builder and the RF stage.
// Assumes: Source and sink share clk_sys.
// Notes: Head word and both flags come straight from flip-flops.
`default_nettype none

module hec_buf2 import hec_pkg::*; (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Drop everything held.
  input wire logic flush,
  // Filling side.
  input wire logic in_valid,
  input wire logic [WORD_W-1:0] in_data,
  output logic in_ready,
  // Draining side.
  output logic out_valid,
  output logic [WORD_W-1:0] out_data,
  input wire logic out_ready
);

  logic [WORD_W-1:0] e0_r, e0_nxt; // Head entry.
  logic [WORD_W-1:0] e1_r, e1_nxt; // Second entry.
  logic [1:0] cnt_r, cnt_nxt; // Words held.
  logic in_ready_r, in_ready_nxt;
  logic out_valid_r, out_valid_nxt;

  // Next state: pop moves the second entry to the head, push fills the first free slot.
  always_comb begin
    logic pop;
    logic push;
    logic [1:0] left;
    pop = out_valid_r & out_ready;
    push = in_valid & in_ready_r;
    left = cnt_r - {1'b0, pop};
    e0_nxt = pop ? e1_r : e0_r;
    e1_nxt = e1_r;
    if (push && left == 2'h0) begin
      e0_nxt = in_data;
    end else if (push) begin
      e1_nxt = in_data;
    end
    cnt_nxt = left + {1'b0, push};
    // A flush wins over a push and drops every word held; the head can still be taken in the flush cycle.
    if (flush) begin
      cnt_nxt = 2'h0;
    end
    out_valid_nxt = (cnt_nxt != 2'h0);
    in_ready_nxt = (cnt_nxt != BUF_DEPTH);
  end

  // Registers only.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      e0_r <= '0;
      e1_r <= '0;
      cnt_r <= 2'h0;
      in_ready_r <= 1'b0;
      out_valid_r <= 1'b0;
    end else begin
      e0_r <= e0_nxt;
      e1_r <= e1_nxt;
      cnt_r <= cnt_nxt;
      in_ready_r <= in_ready_nxt;
      out_valid_r <= out_valid_nxt;
    end
  end

  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = e0_r;

endmodule : hec_buf2

`default_nettype wire

//--- verilog/hec_core.sv
// Purpose: Control core of a button-activated code hopping encoder.
// Assumes: The cipher and the bit level modulator sit downstream.
// Notes: The hop plaintext and the key leave the core for the cipher.
//
// Overview of operation
// - Button press wakes, debounces ten milliseconds first.
// - Hop data carries counter, discrimination, buttons.
// - Sixteen-bit counter increments every transmission.
// - New button aborts word and restarts.
// - Releases ignored; all released finishes, powers down.
// - Store holds twelve sixteen-bit words.
// - Key in words zero to three.
// - Serial in words six, seven; 28 sent.
// - Serial bit 31 enables stuck-button timer.
// - Held 25 seconds enters timeout, stops.
// - All buttons pressed sends the seed.
// - Option bits 0-9 are discrimination value.
// - Option bits 10, 11 are wrap flags.
// - Option bits 13, 14 rate; 15 reserved.
// - Option bit 12 selects battery trip level.
// - Programming uses button 2 clock, output data.
// - Counter wraps clear first, then second flag.
// - Rate chooses element length and word blanking.
// - Trip bit one 9/12 V, zero 6 V.
`default_nettype none

module hec_core import hec_pkg::*; #(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int SHUTOFF_CYCLES = SHUTOFF_CYC,
  parameter int ELEM_SLOW_CYCLES = ELEM_SLOW_CYC,
  parameter int BLINK_CYCLES = BLINK_CYC
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Button pins, active high.
  input wire logic button_input_0,
  input wire logic button_input_1,
  input wire logic button_input_2,
  input wire logic button_input_3,
  // Programming entry strap, active high.
  input wire logic prog_entry,
  // Modulated output pin, data line while programming.
  input wire logic pwm_in,
  output logic pwm_out,
  output logic pwm_oe,
  // Supply comparators for the two trip levels.
  input wire logic supply_low_6v,
  input wire logic supply_low_12v,
  // Indicator, active low.
  output logic indicator_cathode_pin_n,
  // Key for the downstream cipher.
  output logic [63:0] cipher_key,
  // Code word stream toward the RF stage.
  output logic [WORD_W-1:0] cw_data,
  output logic cw_valid,
  input wire logic cw_ready
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_s1_r; // First stage, read only by the second.
  logic [7:0] pin_s2_r; // Second stage, safe to use.
  logic [3:0] btn_s;
  logic data_s, low6_s, low12_s, prog_s;

  // Every pin crosses two flip-flops before any decision sees it.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
    end else begin
      pin_s1_r <= {prog_entry, supply_low_12v, supply_low_6v, pwm_in,
                   button_input_3, button_input_2, button_input_1, button_input_0};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign btn_s = pin_s2_r[3:0];
  assign data_s = pin_s2_r[4];
  assign low6_s = pin_s2_r[5];
  assign low12_s = pin_s2_r[6];
  assign prog_s = pin_s2_r[7];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  hec_state_type state_r, state_nxt; // Main sequence.
  logic [15:0] mem_r [NV_WORDS]; // Parameter store.
  logic [15:0] mem_nxt [NV_WORDS];
  logic [31:0] deb_cnt_r, deb_cnt_nxt; // Debounce time.
  logic [31:0] hold_cnt_r, hold_cnt_nxt; // Stuck-button time.
  logic [31:0] cw_tmr_r, cw_tmr_nxt; // Time within one code word slot.
  logic [31:0] blink_r, blink_nxt; // Indicator blink time.
  logic [3:0] btn_lat_r, btn_lat_nxt; // Buttons sampled after debounce.
  logic [WORD_W-1:0] hop_r, hop_nxt; // Hopping half of the code word.
  logic [1:0] sent_r, sent_nxt; // Words pushed in this slot.
  logic [1:0] slot_r, slot_nxt; // Slot number for blanking.
  logic rpt_r, rpt_nxt; // Repeated code word.
  logic vlow_r, vlow_nxt; // Supply below trip level.
  logic pwm_r, pwm_nxt;
  logic pwm_oe_r, pwm_oe_nxt;
  logic led_n_r, led_n_nxt;
  logic [63:0] key_r, key_nxt;
  logic [15:0] shift_r, shift_nxt; // Programming shift register.
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [3:0] prog_addr_r, prog_addr_nxt;
  logic clk2_prev_r, clk2_prev_nxt; // Last programming clock level.

  // Buffer handshake.
  logic push_valid, push_ready, flush;
  logic [WORD_W-1:0] push_data;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Length of one code word slot in clock cycles for a rate code.
  function automatic logic [31:0] slot_cycles(input logic [1:0] rate);
    logic [31:0] elem;
    case (rate)
      RATE_ALL: elem = 32'(ELEM_SLOW_CYCLES);
      RATE_HALF_MID: elem = 32'(ELEM_MID_CYC);
      default: elem = 32'(ELEM_FAST_CYC);
    endcase
    return 32'(elem * CW_ELEMENTS);
  endfunction : slot_cycles

  // True when this slot is blanked: every second or every fourth word is sent.
  function automatic logic slot_blank(input logic [1:0] rate, input logic [1:0] slot);
    case (rate)
      RATE_ALL: return 1'b0;
      RATE_HALF_MID, RATE_HALF_FAST: return slot[0];
      default: return (slot != 2'h0);
    endcase
  endfunction : slot_blank

  logic [1:0] rate;
  logic blank, auto_off, new_btn;
  // Rate bits sit at 13 and 14; bit 15 is not read.
  assign rate = {mem_r[WA_OPT][OPT_RATE_HI], mem_r[WA_OPT][OPT_RATE_LO]};
  assign blank = slot_blank(rate, slot_r);
  assign auto_off = mem_r[WA_SER_HI][SER_AUTO_OFF];
  assign new_btn = |(btn_s & ~btn_lat_r);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // One process decides the sequence, the store updates and the pins.
  always_comb begin
    logic [15:0] hop_cnt;
    logic [15:0] opt;
    state_nxt = state_r;
    mem_nxt = mem_r;
    deb_cnt_nxt = deb_cnt_r;
    hold_cnt_nxt = hold_cnt_r;
    cw_tmr_nxt = cw_tmr_r;
    blink_nxt = blink_r;
    btn_lat_nxt = btn_lat_r;
    hop_nxt = hop_r;
    sent_nxt = sent_r;
    slot_nxt = slot_r;
    rpt_nxt = rpt_r;
    shift_nxt = shift_r;
    bit_cnt_nxt = bit_cnt_r;
    prog_addr_nxt = prog_addr_r;
    clk2_prev_nxt = btn_s[2];
    push_valid = 1'b0;
    push_data = hop_r;
    flush = 1'b0;
    hop_cnt = mem_r[WA_HOP] + 16'h0001;
    opt = mem_r[WA_OPT];
    // The trip level follows the option bit.
    vlow_nxt = opt[OPT_TRIP] ? low12_s : low6_s;
    // The key is presented most significant word first.
    key_nxt = {mem_r[WA_KEY_HI], mem_r[WA_KEY_2], mem_r[WA_KEY_1], mem_r[WA_KEY_LO]};
    case (state_r)
      // Standby: wait for a press or for programming entry.
      ST_IDLE: begin
        hold_cnt_nxt = 32'h0000_0000;
        deb_cnt_nxt = 32'h0000_0000;
        if (prog_s) begin
          state_nxt = ST_PROG;
          bit_cnt_nxt = 4'h0;
          prog_addr_nxt = WA_KEY_LO;
        end else if (btn_s != 4'h0) begin
          state_nxt = ST_DEB;
        end
      end
      // Debounce, then sample buttons and build the hopping half.
      ST_DEB: begin
        deb_cnt_nxt = deb_cnt_r + 32'h0000_0001;
        if (deb_cnt_r == 32'(DEBOUNCE_CYCLES - 1)) begin
          if (btn_s == 4'h0) begin
            // A bounce with nothing left pressed is not a press.
            state_nxt = ST_IDLE;
          end else begin
            state_nxt = ST_TX;
            btn_lat_nxt = btn_s;
            // Store the new count now, ahead of any word using it.
            mem_nxt[WA_HOP] = hop_cnt;
            if (mem_r[WA_HOP] == HOP_MAX) begin
              // First wrap clears the first flag, the next the second.
              if (opt[OPT_WRAP1]) begin
                opt[OPT_WRAP1] = 1'b0;
              end else begin
                opt[OPT_WRAP2] = 1'b0;
              end
              mem_nxt[WA_OPT] = opt;
            end
            if (btn_s == SEED_BUTTONS) begin
              hop_nxt = {2'b00, mem_r[WA_SEED_HI], mem_r[WA_SEED_LO]};
            end else begin
              // Plaintext for the cipher: buttons, flags, discriminator, count.
              hop_nxt = {2'b00, btn_s, opt[OPT_WRAP2:OPT_WRAP1],
                         opt[OPT_DISC_W-1:0], hop_cnt};
            end
            cw_tmr_nxt = 32'h0000_0000;
            sent_nxt = 2'h0;
            slot_nxt = 2'h0;
            rpt_nxt = 1'b0;
            blink_nxt = 32'h0000_0000;
          end
        end
      end
      // Send code word slots while buttons stay pressed.
      ST_TX: begin
        cw_tmr_nxt = cw_tmr_r + 32'h0000_0001;
        hold_cnt_nxt = hold_cnt_r + 32'h0000_0001;
        blink_nxt = (blink_r == 32'(BLINK_CYCLES - 1)) ? 32'h0000_0000
                                                         : blink_r + 32'h0000_0001;
        if (new_btn) begin
          // Abandon the word in flight and start over.
          flush = 1'b1;
          state_nxt = ST_DEB;
          deb_cnt_nxt = 32'h0000_0000;
        end else if (auto_off && hold_cnt_r == 32'(SHUTOFF_CYCLES - 1)) begin
          // A stuck button stops the transmitter.
          flush = 1'b1;
          state_nxt = ST_TIMEOUT;
        end else begin
          if (!blank && sent_r != 2'h2) begin
            push_valid = 1'b1;
            // Fixed half: status, buttons and low 28 serial bits.
            push_data = (sent_r == 2'h0) ? hop_r
                      : {vlow_r, rpt_r, btn_lat_r, mem_r[WA_SER_HI][SER_TX_W-17:0],
                         mem_r[WA_SER_LO]};
            if (push_ready) begin
              sent_nxt = sent_r + 2'h1;
            end
          end
          // A slot ends when its time is up and its words are away.
          if (cw_tmr_r >= slot_cycles(rate) - 32'h0000_0001 &&
              (blank || sent_r == 2'h2)) begin
            cw_tmr_nxt = 32'h0000_0000;
            sent_nxt = 2'h0;
            slot_nxt = slot_r + 2'h1;
            rpt_nxt = 1'b1;
            // Partial release changes nothing; full release ends here.
            if (btn_s == 4'h0) begin
              state_nxt = ST_IDLE;
            end
          end
        end
      end
      // Silent until every button is released.
      ST_TIMEOUT: begin
        if (btn_s == 4'h0) begin
          state_nxt = ST_IDLE;
        end
      end
      // Serial load: button 2 clocks, the output pin carries data.
      ST_PROG: begin
        if (btn_s[2] && !clk2_prev_r) begin
          shift_nxt = {data_s, shift_r[15:1]};
          bit_cnt_nxt = bit_cnt_r + 4'h1;
          if (bit_cnt_r == 4'hF) begin
            mem_nxt[prog_addr_r] = {data_s, shift_r[15:1]};
            if (prog_addr_r != WA_OPT) begin
              prog_addr_nxt = prog_addr_r + 4'h1;
            end
          end
        end
        if (!prog_s) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Pins for the next cycle.
    pwm_oe_nxt = (state_nxt != ST_PROG);
    pwm_nxt = (state_nxt == ST_TX) && !blank && !flush;
    led_n_nxt = !(state_nxt == ST_TX && !(vlow_r && blink_r >= 32'(BLINK_CYCLES / 2)));
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Store contents are cleared at reset; programming loads them.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      for (int i = 0; i < NV_WORDS; i++) begin
        mem_r[i] <= NV_RESET;
      end
      deb_cnt_r <= 32'h0000_0000;
      hold_cnt_r <= 32'h0000_0000;
      cw_tmr_r <= 32'h0000_0000;
      blink_r <= 32'h0000_0000;
      btn_lat_r <= 4'h0;
      hop_r <= '0;
      sent_r <= 2'h0;
      slot_r <= 2'h0;
      rpt_r <= 1'b0;
      vlow_r <= 1'b0;
      pwm_r <= 1'b0;
      pwm_oe_r <= 1'b1;
      led_n_r <= 1'b1;
      key_r <= 64'h0000_0000_0000_0000;
      shift_r <= 16'h0000;
      bit_cnt_r <= 4'h0;
      prog_addr_r <= 4'h0;
      clk2_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mem_r <= mem_nxt;
      deb_cnt_r <= deb_cnt_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      cw_tmr_r <= cw_tmr_nxt;
      blink_r <= blink_nxt;
      btn_lat_r <= btn_lat_nxt;
      hop_r <= hop_nxt;
      sent_r <= sent_nxt;
      slot_r <= slot_nxt;
      rpt_r <= rpt_nxt;
      vlow_r <= vlow_nxt;
      pwm_r <= pwm_nxt;
      pwm_oe_r <= pwm_oe_nxt;
      led_n_r <= led_n_nxt;
      key_r <= key_nxt;
      shift_r <= shift_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      prog_addr_r <= prog_addr_nxt;
      clk2_prev_r <= clk2_prev_nxt;
    end
  end

  assign pwm_out = pwm_r;
  assign pwm_oe = pwm_oe_r;
  assign indicator_cathode_pin_n = led_n_r;
  assign cipher_key = key_r;

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  // The buffer absorbs a stalled sink; the slot waits for its words.
  hec_buf2 u_buf (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .flush(flush),
    .in_valid(push_valid),
    .in_data(push_data),
    .in_ready(push_ready),
    .out_valid(cw_valid),
    .out_data(cw_data),
    .out_ready(cw_ready)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  debounce_wait_a: assert property (
    (state_r == ST_TX && $past(state_r) == ST_DEB) |->
      $past(deb_cnt_r) == 32'(DEBOUNCE_CYCLES - 1))
    else $error("Transmission started before the debounce time.");

  count_store_a: assert property (
    (state_r == ST_DEB && state_nxt == ST_TX) |=>
      mem_r[WA_HOP] == $past(mem_r[WA_HOP]) + 16'h0001 && hop_r[15:0] == mem_r[WA_HOP]
      || btn_lat_r == SEED_BUTTONS)
    else $error("Hop count not stored with the word that carries it.");

  abort_restart_a: assert property (
    (state_r == ST_TX && new_btn) |=> state_r == ST_DEB && deb_cnt_r == 32'h0000_0000
      ##1 !cw_valid)
    else $error("New button did not abandon the code word.");

  release_done_a: assert property (
    (state_r == ST_TX && state_nxt == ST_IDLE) |->
      btn_s == 4'h0 && cw_tmr_nxt == 32'h0000_0000)
    else $error("Power down before the code word completed.");

  serial_field_a: assert property (
    (push_valid && sent_r == 2'h1) |->
      push_data[27:0] == {mem_r[WA_SER_HI][11:0], mem_r[WA_SER_LO]})
    else $error("Fixed half does not carry the low serial bits.");

  timeout_gate_a: assert property (
    (state_r == ST_TX && state_nxt == ST_TIMEOUT) |->
      auto_off && hold_cnt_r == 32'(SHUTOFF_CYCLES - 1))
    else $error("Timeout without enable or at the wrong time.");

  seed_send_a: assert property (
    (state_r == ST_DEB && state_nxt == ST_TX && btn_s == SEED_BUTTONS) |=>
      hop_r == {2'b00, mem_r[WA_SEED_HI], mem_r[WA_SEED_LO]})
    else $error("Seed not placed in the hopping half.");

  wrap_flag_a: assert property (
    (state_r == ST_DEB && state_nxt == ST_TX && mem_r[WA_HOP] == HOP_MAX &&
     mem_r[WA_OPT][OPT_WRAP1]) |=> !mem_r[WA_OPT][OPT_WRAP1] && mem_r[WA_HOP] == 16'h0000)
    else $error("First wrap did not clear the first flag.");

  blank_slot_a: assert property (
    (state_r == ST_TX && blank) |-> !push_valid)
    else $error("Word pushed in a blanked slot.");

  trip_level_a: assert property (
    ##1 vlow_r == ($past(mem_r[WA_OPT][OPT_TRIP]) ? $past(low12_s) : $past(low6_s)))
    else $error("Low supply flag follows the wrong comparator.");

endmodule : hec_core

`default_nettype wire

//--- verilog/hec_pkg.sv
// Purpose: Shared constants and types of the hopping encoder control core.
// Assumes: A 20 MHz system clock.
// Notes: Word addresses index the twelve-word parameter store.
`default_nettype none

package hec_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int SHUTOFF_S = 25;
  localparam int SHUTOFF_CYC = SHUTOFF_S * CLK_HZ;
  localparam int ELEM_SLOW_US = 400;
  localparam int ELEM_MID_US = 200;
  localparam int ELEM_FAST_US = 100;
  localparam int ELEM_SLOW_CYC = ELEM_SLOW_US * CLK_PER_US;
  localparam int ELEM_MID_CYC = ELEM_MID_US * CLK_PER_US;
  localparam int ELEM_FAST_CYC = ELEM_FAST_US * CLK_PER_US;
  // Full period of the low-supply indicator blink (10 Hz), dark for its second half.
  localparam int BLINK_MS = 100;
  localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
  // Pulse elements that one code word slot lasts, guard time included.
  localparam int CW_ELEMENTS = 150;

  // ----------------------------------------------------------------
  // Parameter store map
  // ----------------------------------------------------------------
  localparam int NV_WORDS = 12;
  localparam logic [3:0] WA_KEY_LO = 4'h0;
  localparam logic [3:0] WA_KEY_1 = 4'h1;
  localparam logic [3:0] WA_KEY_2 = 4'h2;
  localparam logic [3:0] WA_KEY_HI = 4'h3;
  localparam logic [3:0] WA_HOP = 4'h4;
  localparam logic [3:0] WA_RSVD_A = 4'h5;
  localparam logic [3:0] WA_SER_LO = 4'h6;
  localparam logic [3:0] WA_SER_HI = 4'h7;
  localparam logic [3:0] WA_SEED_LO = 4'h8;
  localparam logic [3:0] WA_SEED_HI = 4'h9;
  localparam logic [3:0] WA_RSVD_B = 4'hA;
  localparam logic [3:0] WA_OPT = 4'hB;
  localparam logic [15:0] NV_RESET = 16'h0000;
  localparam logic [15:0] HOP_MAX = 16'hFFFF;

  // Option word and serial word field positions.
  localparam int OPT_DISC_W = 10;
  localparam int OPT_WRAP1 = 10;
  localparam int OPT_WRAP2 = 11;
  localparam int OPT_TRIP = 12;
  localparam int OPT_RATE_LO = 13;
  localparam int OPT_RATE_HI = 14;
  localparam int SER_AUTO_OFF = 15;
  localparam int SER_TX_W = 28;

  // ----------------------------------------------------------------
  // Stream, buttons and modes
  // ----------------------------------------------------------------
  localparam int WORD_W = 34;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  localparam logic [3:0] SEED_BUTTONS = 4'hF;
  localparam logic [1:0] RATE_ALL = 2'h0;
  localparam logic [1:0] RATE_HALF_MID = 2'h1;
  localparam logic [1:0] RATE_HALF_FAST = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEB = 3'h1,
    ST_TX = 3'h3,
    ST_TIMEOUT = 3'h2,
    ST_PROG = 3'h6
  } hec_state_type;

endpackage : hec_pkg

`default_nettype wire
